// ### cpl_pkg.sv
package cpl_pkg;
  // serial link timing: 115200 baud from a 250 MHz clock
  localparam int unsigned CLK_HZ = 250000000;
  localparam int unsigned BAUD = 115200;
  localparam logic [11:0] BIT_CYC = 12'(CLK_HZ / BAUD);
  localparam logic [11:0] HALF_CYC = 12'(CLK_HZ / BAUD / 2);
  // answer deadline, in milliseconds, and its cycle count
  localparam int unsigned ANSWER_MS = 250;
  localparam int unsigned ANSWER_CYC = CLK_HZ / 1000 * ANSWER_MS;
  // packet layout
  localparam logic [7:0] MAX_LEN = 8'h16;
  localparam logic [7:0] PING_MAX = 8'h10;
  localparam logic [7:0] FLASH_LEN = 8'h10;
  localparam logic [7:0] VER_LEN = 8'h10;
  localparam logic [7:0] BOOT_LEN = 8'h03;
  localparam logic [1:0] KIND_CMD = 2'h0;
  localparam logic [1:0] KIND_RSP = 2'h1;
  localparam logic [1:0] KIND_RPT = 2'h2;
  localparam logic [1:0] KIND_ERR = 2'h3;
  // command codes
  localparam logic [5:0] CMD_PING = 6'h00;
  localparam logic [5:0] CMD_VER = 6'h01;
  localparam logic [5:0] CMD_WRFL = 6'h02;
  localparam logic [5:0] CMD_RDFL = 6'h03;
  localparam logic [5:0] CMD_STORE = 6'h04;
  localparam logic [5:0] CMD_BOOT = 6'h05;
  localparam logic [5:0] CMD_CLEAR = 6'h06;
  localparam logic [7:0] RPT_KEY = 8'h80;
  // restart, host reset and host power-off keys
  localparam logic [23:0] KEY_REBOOT = 24'h081263;
  localparam logic [23:0] KEY_HRST = 24'h0C1C61;
  localparam logic [23:0] KEY_HOFF = 24'h030B5F;
  // crc-16 (ccitt reflected, as sent lsb first)
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'h8408;
  // key event codes
  localparam logic [7:0] KEY_RELEASE_OFS = 8'h06;
  localparam int unsigned NKEYS = 6;
  // buffer addressing: 0..21 payload, 32..47 user flash
  localparam logic [5:0] FLASH_BASE = 6'h20;
  // version text, arbitrary identity value
  localparam logic [127:0] VER_TEXT = 128'h4C43443030303A68312E302C76312E30;
  typedef enum logic [3:0] {
    CPL_IDLE = 4'h0,
    CPL_LEN = 4'h1,
    CPL_DATA = 4'h2,
    CPL_CRCL = 4'h3,
    CPL_CRCH = 4'h4,
    CPL_EXEC = 4'h5,
    CPL_TX = 4'h6,
    CPL_TXWAIT = 4'h7
  } cpl_state_t;
endpackage

// ### cpl_mem.sv
`timescale 1ns/100ps
// small byte memory, registered read data
module cpl_mem (
  input wire logic clk,
  input wire logic we,
  input wire logic [5:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic [5:0] raddr,
  output logic [7:0] rdata
);
  logic [7:0] mem [0:63];

  // write port and registered read
  always_ff @(posedge clk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule

// ### cpl_link.sv
`timescale 1ns/100ps
// Contract
// - serial link runs 115200 baud, 8 data bits, no parity, one stop bit
// - packets are type, length, payload, then two check bytes
// - type low six bits carry code, top bits give packet kind
// - length byte counts payload bytes; only zero to 22 legal
// - crc-16 covers type, length, payload; sent low byte first
// - check bytes follow last used payload byte, no padding
// - device answers every received packet within 250 ms; packets with a bad check value or a length over 22 get no answer
// - reports may interleave with answers; host classifies by type
// - enabled key press or release sends type 0x80 report, codes 1..12; code reports one event per cycle, drops events while one is pending
// - exactly one answer per command, low six type bits echoed
// - ping with up to 16 bytes echoes length and payload, type 0x40
// - version query answers type 0x41 with 16 text bytes
// - flash write takes exactly 16 bytes, stores, answers 0x42 empty
// - flash read returns stored user area contents
// - store boot state saves settings, answers type 0x44
// - code 5 with 8,18,99 restarts device, answers 0x45
// - code 5 with 12,28,97 asserts host reset, answers 0x45
// - code 5 with 3,11,95 powers host off, answers 0x45
// - clear screen fills cells with 0x20, homes cursor, answers 0x46
module cpl_link #(
  parameter logic [11:0] BIT_CYC = cpl_pkg::BIT_CYC
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic rx_pin,
  output logic tx_pin,
  input wire logic [5:0] key_press,
  input wire logic [5:0] key_release,
  input wire logic [5:0] press_mask,
  input wire logic [5:0] release_mask,
  output logic store_boot,
  output logic restart_req,
  output logic host_reset,
  output logic host_power_off,
  output logic clear_screen
);
  localparam logic [11:0] HALF_CYC = BIT_CYC >> 1;
  cpl_pkg::cpl_state_t state;
  logic rx_s1, rx_s2;
  // receiver
  logic [11:0] rx_cnt;
  logic [3:0] rx_bit;
  logic [7:0] rx_sh;
  logic rx_busy, rx_vld;
  logic [7:0] rx_byte;
  // packet capture
  logic [7:0] p_type, p_len, p_idx;
  logic [15:0] crc, rx_crc;
  logic [23:0] key3;
  // transmitter
  logic [11:0] tx_cnt;
  logic [3:0] tx_bit;
  logic [9:0] tx_sh;
  logic tx_busy;
  logic [7:0] a_type, a_len, t_idx;
  logic [1:0] a_src;
  logic [15:0] tcrc;
  logic [2:0] t_phase;
  logic [7:0] key_code;
  logic key_pend;
  logic [7:0] mem_rd;
  logic flash_copy;
  logic [4:0] fc_cnt;
  logic [7:0] rpt_code;

  // two-flop synchroniser on the serial input
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rx_s1 <= 1'b1;
      rx_s2 <= 1'b1;
    end
    else
    begin
      rx_s1 <= rx_pin;
      rx_s2 <= rx_s1;
    end
  end

  // uart receive, samples mid-bit, 8n1
  wire rx_tick = rx_busy && (rx_cnt == 12'h000);
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rx_busy <= 1'b0;
      rx_cnt <= 12'h000;
      rx_bit <= 4'h0;
      rx_sh <= 8'h00;
      rx_vld <= 1'b0;
      rx_byte <= 8'h00;
    end
    else
    begin
      rx_vld <= 1'b0;
      if (!rx_busy && !rx_s2)
      begin
        rx_busy <= 1'b1;
        rx_cnt <= HALF_CYC;
        rx_bit <= 4'h0;
      end
      else if (rx_tick)
      begin
        rx_cnt <= BIT_CYC - 12'h001;
        rx_bit <= rx_bit + 4'h1;
        if (rx_bit == 4'h0 && rx_s2)
          rx_busy <= 1'b0;
        else if (rx_bit == 4'h9)
        begin
          rx_busy <= 1'b0;
          rx_vld <= rx_s2;
          rx_byte <= rx_sh;
        end
        else if (rx_bit != 4'h0)
          rx_sh <= {rx_s2, rx_sh[7:1]};
      end
      else if (rx_busy)
        rx_cnt <= rx_cnt - 12'h001;
    end
  end

  // crc-16 byte update
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++)
      r = r[0] ? ((r >> 1) ^ cpl_pkg::CRC_POLY) : (r >> 1);
    return r;
  endfunction

  // command legality per code
  wire [5:0] code = p_type[5:0];
  wire crc_ok = (crc == ~rx_crc) || (~crc == rx_crc);
  wire cmd_kind = (p_type[7:6] == cpl_pkg::KIND_CMD);
  wire is_boot = (key3 == cpl_pkg::KEY_REBOOT) || (key3 == cpl_pkg::KEY_HRST)
    || (key3 == cpl_pkg::KEY_HOFF);
  wire legal = cmd_kind && (
    (code == cpl_pkg::CMD_PING && p_len <= cpl_pkg::PING_MAX) ||
    (code == cpl_pkg::CMD_VER && p_len == 8'h00) ||
    (code == cpl_pkg::CMD_WRFL && p_len == cpl_pkg::FLASH_LEN) ||
    (code == cpl_pkg::CMD_RDFL && p_len == 8'h00) ||
    (code == cpl_pkg::CMD_STORE && p_len == 8'h00) ||
    (code == cpl_pkg::CMD_BOOT && p_len == cpl_pkg::BOOT_LEN && is_boot) ||
    (code == cpl_pkg::CMD_CLEAR && p_len == 8'h00));
  // answer length and payload source: 0 none, 1 rx buffer, 2 flash, 3 text
  wire [7:0] ans_len = !legal ? 8'h00 :
    code == cpl_pkg::CMD_PING ? p_len :
    code == cpl_pkg::CMD_VER ? cpl_pkg::VER_LEN :
    code == cpl_pkg::CMD_RDFL ? cpl_pkg::FLASH_LEN : 8'h00;
  wire [1:0] ans_src = !legal ? 2'h0 : code == cpl_pkg::CMD_PING ? 2'h1 :
    code == cpl_pkg::CMD_RDFL ? 2'h2 : code == cpl_pkg::CMD_VER ? 2'h3 : 2'h0;
  wire [7:0] ans_type = {legal ? cpl_pkg::KIND_RSP : cpl_pkg::KIND_ERR, code};

  // buffer: payload at 0.., flash copy at FLASH_BASE..
  wire in_data = (state == cpl_pkg::CPL_DATA) && rx_vld;
  wire do_wrfl = (state == cpl_pkg::CPL_EXEC) && crc_ok && legal && code == cpl_pkg::CMD_WRFL;
  wire [5:0] wr_addr = in_data ? p_idx[5:0] : (cpl_pkg::FLASH_BASE + t_idx[5:0]);
  wire tx_tick = tx_busy && (tx_cnt == 12'h000);
  wire tx_done = tx_tick && (tx_bit == 4'h9);
  // flash copy and answer reads look one byte ahead of the registered read
  wire adv_idx = (state == cpl_pkg::CPL_TXWAIT) && tx_done && (t_phase == 3'h2);
  wire [5:0] rd_idx = (flash_copy || adv_idx) ? (t_idx[5:0] + 6'h01) : t_idx[5:0];
  wire [5:0] rd_addr = (a_src == 2'h2 && state != cpl_pkg::CPL_EXEC) ?
    (cpl_pkg::FLASH_BASE + rd_idx) : rd_idx;
  wire [7:0] ver_byte = cpl_pkg::VER_TEXT[8'(8'd127 - {t_idx[3:0], 3'h0}) -: 8];

  cpl_mem u_mem (
    .clk(clk),
    .we(in_data || flash_copy),
    .waddr(wr_addr),
    .wdata(in_data ? rx_byte : mem_rd),
    .raddr(rd_addr),
    .rdata(mem_rd)
  );

  // tx character engine
  logic tx_load;
  logic [7:0] tx_byte;
  // pick next answer byte
  wire [7:0] pay_byte = (a_src == 2'h3) ? ver_byte : mem_rd;
  wire [7:0] next_tx = (t_phase == 3'h0) ? a_type : (t_phase == 3'h1) ? a_len :
    (t_phase == 3'h2) ? pay_byte : (t_phase == 3'h3) ? tcrc[7:0] : tcrc[15:8];

  // key event encode, any enabled press wins over any release, then lowest set bit wins
  logic [7:0] key_sel;
  logic key_any;
  always_comb
  begin
    key_sel = 8'h00;
    key_any = 1'b0;
    for (int k = cpl_pkg::NKEYS - 1; k >= 0; k--)
    begin
      if (key_release[k] && release_mask[k])
      begin
        key_sel = 8'(k + 1) + cpl_pkg::KEY_RELEASE_OFS;
        key_any = 1'b1;
      end
    end
    for (int k = cpl_pkg::NKEYS - 1; k >= 0; k--)
    begin
      if (key_press[k] && press_mask[k])
      begin
        key_sel = 8'(k + 1);
        key_any = 1'b1;
      end
    end
  end

  // main packet sequencer
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state <= cpl_pkg::CPL_IDLE;
      p_type <= 8'h00;
      p_len <= 8'h00;
      p_idx <= 8'h00;
      crc <= cpl_pkg::CRC_INIT;
      rx_crc <= 16'h0000;
      key3 <= 24'h000000;
      a_type <= 8'h00;
      a_len <= 8'h00;
      a_src <= 2'h0;
      t_idx <= 8'h00;
      tcrc <= cpl_pkg::CRC_INIT;
      t_phase <= 3'h0;
      tx_load <= 1'b0;
      tx_byte <= 8'h00;
      flash_copy <= 1'b0;
      fc_cnt <= 5'h00;
      key_pend <= 1'b0;
      key_code <= 8'h00;
      rpt_code <= 8'h00;
      store_boot <= 1'b0;
      restart_req <= 1'b0;
      host_reset <= 1'b0;
      host_power_off <= 1'b0;
      clear_screen <= 1'b0;
    end
    else
    begin
      tx_load <= 1'b0;
      store_boot <= 1'b0;
      restart_req <= 1'b0;
      clear_screen <= 1'b0;
      if (key_any && !key_pend)
      begin
        key_pend <= 1'b1;
        key_code <= key_sel;
      end
      case (state)
        cpl_pkg::CPL_IDLE:
        begin
          if (rx_vld)
          begin
            p_type <= rx_byte;
            crc <= crc_step(cpl_pkg::CRC_INIT, rx_byte);
            state <= cpl_pkg::CPL_LEN;
          end
          else if (key_pend && !tx_busy)
          begin
            // key report, sent between packets
            a_type <= cpl_pkg::RPT_KEY;
            rpt_code <= key_code; // later events cannot alter this report
            a_len <= 8'h01;
            a_src <= 2'h0;
            key_pend <= 1'b0;
            tcrc <= cpl_pkg::CRC_INIT;
            t_phase <= 3'h0;
            t_idx <= 8'h00;
            state <= cpl_pkg::CPL_TX;
          end
        end
        cpl_pkg::CPL_LEN:
        begin
          if (rx_vld)
          begin
            p_len <= rx_byte;
            p_idx <= 8'h00;
            crc <= crc_step(crc, rx_byte);
            if (rx_byte > cpl_pkg::MAX_LEN)
              state <= cpl_pkg::CPL_IDLE;
            else if (rx_byte == 8'h00)
              state <= cpl_pkg::CPL_CRCL;
            else
              state <= cpl_pkg::CPL_DATA;
          end
        end
        cpl_pkg::CPL_DATA:
        begin
          if (rx_vld)
          begin
            crc <= crc_step(crc, rx_byte);
            key3 <= {key3[15:0], rx_byte};
            p_idx <= p_idx + 8'h01;
            if (p_idx + 8'h01 == p_len)
              state <= cpl_pkg::CPL_CRCL;
          end
        end
        cpl_pkg::CPL_CRCL:
        begin
          if (rx_vld)
          begin
            rx_crc[7:0] <= rx_byte;
            state <= cpl_pkg::CPL_CRCH;
          end
        end
        cpl_pkg::CPL_CRCH:
        begin
          if (rx_vld)
          begin
            rx_crc[15:8] <= rx_byte;
            t_idx <= 8'h00;
            state <= cpl_pkg::CPL_EXEC;
          end
        end
        cpl_pkg::CPL_EXEC:
        begin
          if (flash_copy)
          begin
            t_idx <= t_idx + 8'h01;
            fc_cnt <= fc_cnt - 5'h01;
            if (fc_cnt == 5'h01)
              flash_copy <= 1'b0;
          end
          else if (!crc_ok)
            state <= cpl_pkg::CPL_IDLE;
          else if (do_wrfl && fc_cnt == 5'h00 && t_idx == 8'h00)
          begin
            flash_copy <= 1'b1;
            fc_cnt <= 5'(cpl_pkg::FLASH_LEN);
            t_idx <= 8'h00;
          end
          else
          begin
            // side effects only for legal commands
            store_boot <= legal && code == cpl_pkg::CMD_STORE;
            clear_screen <= legal && code == cpl_pkg::CMD_CLEAR;
            restart_req <= legal && code == cpl_pkg::CMD_BOOT && key3 == cpl_pkg::KEY_REBOOT;
            if (legal && code == cpl_pkg::CMD_BOOT && key3 == cpl_pkg::KEY_HRST)
              host_reset <= 1'b1;
            if (legal && code == cpl_pkg::CMD_BOOT && key3 == cpl_pkg::KEY_HOFF)
              host_power_off <= 1'b1;
            a_type <= ans_type;
            a_len <= ans_len;
            a_src <= ans_src;
            tcrc <= cpl_pkg::CRC_INIT;
            t_phase <= 3'h0;
            t_idx <= 8'h00;
            state <= cpl_pkg::CPL_TX;
          end
        end
        cpl_pkg::CPL_TX:
        begin
          if (!tx_busy && !tx_load)
          begin
            tx_byte <= (a_type == cpl_pkg::RPT_KEY && t_phase == 3'h2) ? rpt_code : next_tx;
            tx_load <= 1'b1;
            if (t_phase < 3'h3)
              tcrc <= crc_step(tcrc, (a_type == cpl_pkg::RPT_KEY && t_phase == 3'h2)
                ? rpt_code : next_tx);
            state <= cpl_pkg::CPL_TXWAIT;
          end
        end
        cpl_pkg::CPL_TXWAIT:
        begin
          if (tx_done)
          begin
            state <= cpl_pkg::CPL_TX;
            if (t_phase == 3'h1)
              t_phase <= (a_len == 8'h00) ? 3'h3 : 3'h2;
            else if (t_phase == 3'h2)
            begin
              t_idx <= t_idx + 8'h01;
              if (t_idx + 8'h01 == a_len)
                t_phase <= 3'h3;
            end
            else if (t_phase == 3'h4)
              state <= cpl_pkg::CPL_IDLE;
            else
              t_phase <= t_phase + 3'h1;
          end
        end
        default:
          state <= cpl_pkg::CPL_IDLE;
      endcase
    end
  end

  // uart transmit, crc sent complemented low byte first
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      tx_busy <= 1'b0;
      tx_cnt <= 12'h000;
      tx_bit <= 4'h0;
      tx_sh <= 10'h3FF;
      tx_pin <= 1'b1;
    end
    else if (tx_load)
    begin
      tx_busy <= 1'b1;
      tx_cnt <= BIT_CYC - 12'h001;
      tx_bit <= 4'h0;
      tx_sh <= {1'b1, (t_phase >= 3'h3) ? ~tx_byte : tx_byte, 1'b0};
      tx_pin <= 1'b0;
    end
    else if (tx_tick)
    begin
      tx_cnt <= BIT_CYC - 12'h001;
      tx_bit <= tx_bit + 4'h1;
      tx_sh <= {1'b1, tx_sh[9:1]};
      tx_pin <= tx_sh[1];
      if (tx_bit == 4'h9)
      begin
        tx_busy <= 1'b0;
        tx_pin <= 1'b1;
      end
    end
    else if (tx_busy)
      tx_cnt <= tx_cnt - 12'h001;
  end

  // answer type echoes command code
  a_echo_code: assert property (@(posedge clk) disable iff (!rst_b)
    state == cpl_pkg::CPL_EXEC && !flash_copy && crc_ok && !do_wrfl
    |=> a_type[5:0] == $past(code))
    else $error("answer code not echoed");
  // illegal packet answered as error, no store or clear pulse
  a_err_kind: assert property (@(posedge clk) disable iff (!rst_b)
    state == cpl_pkg::CPL_EXEC && !flash_copy && crc_ok && !legal
    |=> a_type[7:6] == cpl_pkg::KIND_ERR && !store_boot && !clear_screen)
    else $error("illegal packet not refused");
  // length never exceeds limit once data begins
  a_len_limit: assert property (@(posedge clk) disable iff (!rst_b)
    state == cpl_pkg::CPL_DATA |-> p_len <= cpl_pkg::MAX_LEN && p_len != 8'h00)
    else $error("payload length out of range");
  // line idles high outside characters
  a_line_idle: assert property (@(posedge clk) disable iff (!rst_b)
    !tx_busy && !$past(tx_load) |-> tx_pin)
    else $error("line not idle");
  // host reset only after the matching key
  a_host_rst: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(host_reset) |-> $past(key3) == cpl_pkg::KEY_HRST)
    else $error("host reset without key");
  // power-off only after the matching key
  a_host_off: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(host_power_off) |-> $past(key3) == cpl_pkg::KEY_HOFF)
    else $error("power off without key");
  // key report payload is a legal code
  a_key_code: assert property (@(posedge clk) disable iff (!rst_b)
    state == cpl_pkg::CPL_TX && a_type == cpl_pkg::RPT_KEY
    |-> rpt_code >= 8'h01 && rpt_code <= 8'h0C)
    else $error("bad key code");
  // ping answer keeps length
  a_ping_len: assert property (@(posedge clk) disable iff (!rst_b)
    state == cpl_pkg::CPL_EXEC && !flash_copy && crc_ok && legal && code == cpl_pkg::CMD_PING
    |=> a_len == $past(p_len))
    else $error("ping length changed");
endmodule

// ### cpl_host_model.sv
`timescale 1ns/100ps
// behavioural host: sends packets on the serial line and collects answer bytes
module cpl_host_model #(
  parameter logic [11:0] BIT_CYC = cpl_pkg::BIT_CYC
) (
  input wire logic clk,
  output logic rx_pin,
  input wire logic tx_pin
);
  logic [7:0] got_q[$];
  logic stop_bad = 1'h0;
  initial rx_pin = 1'h1;

  // crc-16, reflected poly, preset all ones, final complement
  function automatic logic [15:0] crc16(input logic [7:0] b[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (b[i])
    begin
      c = c ^ {8'h00, b[i]};
      for (int k = 0; k < 8; k++)
        c = c[0] ? ((c >> 1) ^ 16'h8408) : (c >> 1);
    end
    return ~c;
  endfunction

  // one character: start bit, eight data bits lsb first, one stop bit
  task automatic send_byte(input logic [7:0] v);
    logic [9:0] f;
    f = {1'h1, v, 1'h0};
    for (int i = 0; i < 10; i++)
    begin
      @(posedge clk);
      #1 rx_pin = f[i];  // 8N1 at the link rate
      repeat (BIT_CYC - 12'h001) @(posedge clk);
    end
  endtask

  // whole packet; bad flips the low bit of the check value
  task automatic send_pkt(input logic [7:0] typ, input logic [7:0] pl[$], input logic bad);
    logic [7:0] b[$];
    logic [15:0] c;
    b = {typ, 8'(pl.size())};  // type, length, payload
    b = {b, pl};
    c = crc16(b) ^ {15'h0000, bad};
    b = {b, c[7:0], c[15:8]};  // check bytes low first, no padding
    foreach (b[i])
      send_byte(b[i]);
  endtask

  // receiver: start edge, mid-bit sampling, stop bit must be high
  initial
  begin
    logic [7:0] v;
    forever
    begin
      @(negedge tx_pin);
      repeat (BIT_CYC >> 1) @(posedge clk);
      for (int i = 0; i < 8; i++)
      begin
        repeat (BIT_CYC) @(posedge clk);
        v[i] = tx_pin;
      end
      repeat (BIT_CYC) @(posedge clk);
      stop_bad = stop_bad | ~tx_pin;  // one stop bit
      got_q.push_back(v);  // buffered until the bench drains it
    end
  end
endmodule

// ### tb_crc_packet_host_command_link.sv
`timescale 1ns/100ps
// self-checking bench for the host command link
module tb_crc_packet_host_command_link;
  logic clk, rst_b, rx_pin, tx_pin;
  logic [5:0] key_press, key_release, press_mask, release_mask;
  logic store_boot, restart_req, host_reset, host_power_off, clear_screen;
  int failures = 0;
  int total_checks = 0;
  int seed = 74;
  int n_store = 0;
  int n_restart = 0;
  int n_clear = 0;
  // short link bit so the whole run stays brief
  localparam logic [11:0] BIT_CYC = 12'h010;

  cpl_link #(.BIT_CYC(BIT_CYC)) cpl_link_i (.clk(clk), .rst_b(rst_b), .rx_pin(rx_pin),
    .tx_pin(tx_pin),
    .key_press(key_press), .key_release(key_release), .press_mask(press_mask),
    .release_mask(release_mask), .store_boot(store_boot), .restart_req(restart_req),
    .host_reset(host_reset), .host_power_off(host_power_off), .clear_screen(clear_screen));
  cpl_host_model #(.BIT_CYC(BIT_CYC)) cpl_host_model_i (.clk(clk), .rx_pin(rx_pin),
    .tx_pin(tx_pin));

  // clock
  initial
  begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end

  // count side-effect pulses
  always @(posedge clk)
  begin
    n_store <= n_store + int'(store_boot === 1'h1);
    n_restart <= n_restart + int'(restart_req === 1'h1);
    n_clear <= n_clear + int'(clear_screen === 1'h1);
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // next answer byte, bounded wait
  task automatic get_byte(output logic [7:0] v);
    int n;
    n = 0;
    // give up on a silent device, as a retrying host would
    while (cpl_host_model_i.got_q.size() == 0 && n < 40 * BIT_CYC)
    begin
      @(posedge clk);
      n++;
    end
    v = 8'h00;
    if (cpl_host_model_i.got_q.size() == 0)
      check("answer byte arrival", 32'h0, 32'h1);
    else
      v = cpl_host_model_i.got_q.pop_front();
  endtask

  // one packet from the device, its check value verified
  task automatic get_pkt(output logic [7:0] typ, output logic [7:0] pl[$]);
    logic [7:0] len, lo, hi, v;
    logic [15:0] c;
    pl = {};
    get_byte(typ);
    get_byte(len);
    check("length range", {31'h0, len <= 8'h16}, 32'h1);
    for (int i = 0; i < len && i < 22; i++)
    begin
      get_byte(v);
      pl.push_back(v);
    end
    get_byte(lo);
    get_byte(hi);
    c = cpl_host_model_i.crc16({typ, len, pl});
    check("answer crc", {16'h0, hi, lo}, {16'h0, c});
  endtask

  task automatic xact(input logic [7:0] cmd, input logic [7:0] pl[$], input logic [7:0] et,
    input logic [7:0] ep[$]);
    logic [7:0] t;
    logic [7:0] r[$];
    cpl_host_model_i.send_pkt(cmd, pl, 1'h0);
    get_pkt(t, r);  // next command only after this answer
    check("answer type", {24'h0, t}, {24'h0, et});
    check("answer length", r.size(), ep.size());
    foreach (ep[i])
      if (i < r.size())
        check("answer payload", {24'h0, r[i]}, {24'h0, ep[i]});
    $display("test command %h done", cmd);
  endtask

  // watchdog: about 200 characters of traffic plus idle gaps, with margin
  initial
  begin
    repeat (4000 * BIT_CYC) @(posedge clk);
    check("watchdog", 32'h1, 32'h0);
    end_of_test();
  end

  // main sequence
  initial
  begin
    logic [7:0] p[$];
    logic [7:0] fl[$];
    logic [7:0] none[$];
    logic [7:0] ver[$];
    logic [7:0] t;
    int n, s;
    logic [23:0] keys[3];
    rst_b = 1'h0;
    key_press = 6'h00;
    key_release = 6'h00;
    press_mask = 6'h3F;
    release_mask = 6'h3E;
    repeat (10) @(posedge clk);
    #1 rst_b = 1'h1;
    n = $unsigned($random(seed)) % 17;
    for (int i = 0; i < n; i++)
      p.push_back(8'($random(seed)));
    xact(8'h00, p, 8'h40, p);
    for (int i = 15; i >= 0; i--)
      ver.push_back(cpl_pkg::VER_TEXT[i*8 +: 8]);
    xact(8'h01, none, 8'h41, ver);
    for (int i = 0; i < 16; i++)
      fl.push_back(8'($random(seed)));
    xact(8'h02, fl, 8'h42, none);
    xact(8'h03, none, 8'h43, fl);
    s = n_store;
    xact(8'h04, none, 8'h44, none);
    check("store pulses", n_store - s, 32'h1);
    xact(8'h04, {8'h01}, 8'hC4, none);
    check("store after error", n_store - s, 32'h1);
    s = n_clear;
    xact(8'h06, none, 8'h46, none);
    check("clear pulses", n_clear - s, 32'h1);
    p = {};
    for (int i = 0; i < 17; i++)
      p.push_back(8'($random(seed)));
    xact(8'h00, p, 8'hC0, none);
    xact(8'h05, {8'h08, 8'h12, 8'h62}, 8'hC5, none);
    check("side effects after error", {n_restart[29:0], host_reset, host_power_off},
      32'h0);
    keys = '{cpl_pkg::KEY_REBOOT, cpl_pkg::KEY_HRST, cpl_pkg::KEY_HOFF};
    foreach (keys[k])
      xact(8'h05, {keys[k][23:16], keys[k][15:8], keys[k][7:0]}, 8'h45, none);
    check("restart pulses", n_restart, 32'h1);
    check("host reset level", {31'h0, host_reset}, 32'h1);
    check("host power off level", {31'h0, host_power_off}, 32'h1);
    cpl_host_model_i.send_pkt(8'h00, none, 1'h1);
    repeat (40 * BIT_CYC) @(posedge clk);
    check("answer to bad crc", cpl_host_model_i.got_q.size(), 32'h0);
    $display("test error cases done");
    // key press, then a masked release followed by an enabled one
    @(posedge clk);
    #1 key_press = 6'h04;
    @(posedge clk);
    #1 key_press = 6'h00;
    get_pkt(t, p);
    check("press report", {t, p.size() == 1, p[0]}, {8'h80, 1'h1, 8'h03});
    #1 key_release = 6'h01;
    @(posedge clk);
    #1 key_release = 6'h02;
    @(posedge clk);
    #1 key_release = 6'h00;
    get_pkt(t, p);
    check("release report", {t, p.size() == 1, p[0]}, {8'h80, 1'h1, 8'h08});
    repeat (40 * BIT_CYC) @(posedge clk);
    check("masked event silent", cpl_host_model_i.got_q.size(), 32'h0);
    check("stop bits", {31'h0, cpl_host_model_i.stop_bad}, 32'h0);
    $display("test key reports done");
    end_of_test();
  end
endmodule
